// [include/gdfc_params.svh]
// Timing constants of the gate driver fault controller.
`ifndef GDFC_PARAMS_SVH
`define GDFC_PARAMS_SVH
`define GDFC_CLK_PERIOD_NS      10
`define GDFC_TURN_ON_LAT_NS     100
`define GDFC_TURN_OFF_LAT_NS    125
`define GDFC_ACK_DELAY_NS       190
`define GDFC_ACK_WIDTH_NS       600
`define GDFC_ACK_MIN_NS         400
`define GDFC_ACK_MAX_NS         1050
`define GDFC_RESPONSE_US        8
`define GDFC_BLOCK_US           8
`define GDFC_STRETCH_US         8
`define GDFC_SC_OFF_NS          200
`define GDFC_TURN_ON_CYC   ((`GDFC_TURN_ON_LAT_NS + `GDFC_CLK_PERIOD_NS - 1) / `GDFC_CLK_PERIOD_NS)
`define GDFC_TURN_OFF_CYC  ((`GDFC_TURN_OFF_LAT_NS + `GDFC_CLK_PERIOD_NS - 1) / `GDFC_CLK_PERIOD_NS)
`define GDFC_ACK_DELAY_CYC (`GDFC_ACK_DELAY_NS / `GDFC_CLK_PERIOD_NS)
`define GDFC_ACK_CYC       (`GDFC_ACK_WIDTH_NS / `GDFC_CLK_PERIOD_NS)
`define GDFC_RESPONSE_CYC  (`GDFC_RESPONSE_US * 1000 / `GDFC_CLK_PERIOD_NS)
`define GDFC_BLOCK_CYC     (`GDFC_BLOCK_US * 1000 / `GDFC_CLK_PERIOD_NS)
`define GDFC_STRETCH_CYC   (`GDFC_STRETCH_US * 1000 / `GDFC_CLK_PERIOD_NS)
`define GDFC_SC_OFF_CYC    (`GDFC_SC_OFF_NS / `GDFC_CLK_PERIOD_NS)
`endif

// [include/gdfc_pkg.sv]
// Types of the gate driver fault controller.
package gdfc_pkg;
    typedef logic [15:0] gdfc_cnt_t;
    typedef enum logic [2:0] {
        GDFC_OFF    = 3'b000,
        GDFC_ON_RES = 3'b001,
        GDFC_ON_OK  = 3'b010,
        GDFC_SC_DLY = 3'b011,
        GDFC_SC_BLK = 3'b100,
        GDFC_LOCK   = 3'b101
    } gdfc_state_t;
endpackage : gdfc_pkg

// [logic/gdfc_delay_line.sv]
// Fixed-latency delay of a one-bit level with separate rise and fall latencies.
`timescale 1ns/100ps
module gdfc_delay_line
    import gdfc_pkg::*;
#(
    parameter gdfc_cnt_t RISE_CYC = 16'h000A,
    parameter gdfc_cnt_t FALL_CYC = 16'h000D
)
(
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst,
    // Level in and delayed level out.
    input  wire logic din,
    output logic      dout
);
    gdfc_cnt_t cnt_q;
    logic      tgt_q;
    logic      dout_q;
    // A change that reverses before it has matured restarts the count.
    wire logic      differs  = din != dout_q;
    wire gdfc_cnt_t lat      = din ? RISE_CYC : FALL_CYC;
    wire logic      matured  = differs && (cnt_q + 16'h0001 >= lat);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q  <= 16'h0000;
            tgt_q  <= 1'b0;
            dout_q <= 1'b0;
        end
        else
        begin
            tgt_q  <= din;
            cnt_q  <= (!differs || matured || tgt_q != din) ? 16'h0000 : cnt_q + 16'h0001;
            if (matured)
                dout_q <= din;
        end
    end

    assign dout = dout_q;
endmodule : gdfc_delay_line

// [logic/gdfc_core.sv]
// Control logic of a single-channel gate driver with optical command and status links.
// What this block does
// R1 - Gate on while command light present, off while absent.
// R2 - Command edges reach the gate after fixed, direction-specific latencies.
// R3 - Status light on when healthy; any failure turns it off.
// R4 - Command edges answered by short status light-off pulses; an edge during the delay or pulse of an earlier one shares that pulse.
// R5 - Undervoltage lock turns status light off and forces gate off.
// R6 - Undervoltage fault held for as long as the condition lasts.
// R7 - Fault shown during power-up until both rails clear their thresholds.
// R8 - Under lock, gate control moves from positive to negative rail.
// R9 - After turn-on, wait response time, then compare desaturation sense.
// R10 - Declared short circuit turns status light off at once.
// R11 - Gate switched off turn-off delay after response time ends.
// R12 - Short-circuit fault clears itself after blocking time; light off meanwhile.
// R13 - After shutdown, gate stays off until a fresh rising command edge.
// R14 - Controller may check each acknowledge to supervise driver and link.
// R15 - Acknowledge reaches controller about 190 ns after a command edge.
// R16 - Acknowledge pulse lasts 400 to 1050 ns, nominally 600 ns.
// R17 - Undervoltage fault indication stretched about 8 us after the condition ends.
// R18 - Detection to gate turn-off is about 0.2 us.
// R19 - All intervals timed by counters on the logic clock.
// R20 - Fault indication outranks acknowledge; light off until both end.
`timescale 1ns/100ps
`include "gdfc_params.svh"
module gdfc_core
    import gdfc_pkg::*;
#(
    parameter gdfc_cnt_t RESPONSE_CYC = gdfc_cnt_t'(`GDFC_RESPONSE_CYC),
    parameter gdfc_cnt_t BLOCK_CYC    = gdfc_cnt_t'(`GDFC_BLOCK_CYC),
    parameter gdfc_cnt_t STRETCH_CYC  = gdfc_cnt_t'(`GDFC_STRETCH_CYC)
)
(
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst,
    // Optical links, light present is high.
    input  wire logic command_light_input,
    output logic      status_light_output,
    // Secondary-side supply monitors, high while each rail is above clearance.
    input  wire logic positive_rail_ok,
    input  wire logic negative_rail_ok,
    // Desaturation comparator, high when sense exceeds threshold.
    input  wire logic desat_over_threshold,
    // Gate stage controls.
    output logic      gate_on,
    output logic      positive_gate_rail_ctrl,
    output logic      negative_gate_rail_ctrl,
    // Observation of the lock state.
    output logic      supply_undervoltage_lock
);
    localparam gdfc_cnt_t SC_OFF_CYC    = gdfc_cnt_t'(`GDFC_SC_OFF_CYC);
    localparam gdfc_cnt_t ACK_CYC       = gdfc_cnt_t'(`GDFC_ACK_CYC);
    localparam gdfc_cnt_t ACK_DELAY_CYC = gdfc_cnt_t'(`GDFC_ACK_DELAY_CYC);

    function automatic logic done(input gdfc_cnt_t c, input gdfc_cnt_t lim);
        done = (c + 16'h0001) >= lim;
    endfunction : done

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] cmd_s_q;
    logic [2:0] pos_s_q;
    logic [2:0] neg_s_q;
    logic [2:0] des_s_q;
    logic       cmd_q;
    logic       pos_q;
    logic       neg_q;
    logic       des_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_s_q <= 3'h0;
            pos_s_q <= 3'h0;
            neg_s_q <= 3'h0;
            des_s_q <= 3'h0;
            cmd_q   <= 1'b0;
            pos_q   <= 1'b0;
            neg_q   <= 1'b0;
            des_q   <= 1'b0;
        end
        else
        begin
            cmd_s_q <= {cmd_s_q[1:0], command_light_input};
            pos_s_q <= {pos_s_q[1:0], positive_rail_ok};
            neg_s_q <= {neg_s_q[1:0], negative_rail_ok};
            des_s_q <= {des_s_q[1:0], desat_over_threshold};
            if (cmd_s_q[1] == cmd_s_q[2])
                cmd_q <= cmd_s_q[2];
            if (pos_s_q[1] == pos_s_q[2])
                pos_q <= pos_s_q[2];
            if (neg_s_q[1] == neg_s_q[2])
                neg_q <= neg_s_q[2];
            if (des_s_q[1] == des_s_q[2])
                des_q <= des_s_q[2];
        end
    end

    // Command with turn-on and turn-off latency applied.
    logic cmd_dly;
    gdfc_delay_line #(
        .RISE_CYC (gdfc_cnt_t'(`GDFC_TURN_ON_CYC)),
        .FALL_CYC (gdfc_cnt_t'(`GDFC_TURN_OFF_CYC))
    ) u_cmd_delay (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (cmd_q),
        .dout    (cmd_dly)
    ); // [R2]

    logic      cmd_dly_prev_q;
    logic      cmd_prev_q;
    wire logic cmd_rise = cmd_dly && !cmd_dly_prev_q;
    wire logic cmd_edge = cmd_q != cmd_prev_q;
    // Both rails must be clear; reset leaves them unproven, so power-up shows a fault.
    wire logic uv_lock  = !(pos_q && neg_q); // [R5] [R7]

    // Short-circuit sequencer.
    gdfc_state_t st_q;
    gdfc_state_t st_d;
    gdfc_cnt_t   sc_cnt_q;
    wire logic   sc_tick = done(sc_cnt_q, st_q == GDFC_ON_RES ? RESPONSE_CYC :
                                st_q == GDFC_SC_DLY ? SC_OFF_CYC : BLOCK_CYC); // [R19]

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            GDFC_OFF:
                if (cmd_rise && !uv_lock)
                    st_d = GDFC_ON_RES;
            GDFC_ON_RES:
                if (!cmd_dly || uv_lock)
                    st_d = GDFC_OFF;
                else if (sc_tick)
                    st_d = des_q ? GDFC_SC_DLY : GDFC_ON_OK; // [R9]
            GDFC_ON_OK:
                if (!cmd_dly || uv_lock)
                    st_d = GDFC_OFF;
            GDFC_SC_DLY:
                if (sc_tick)
                    st_d = GDFC_SC_BLK; // [R11] [R18]
            GDFC_SC_BLK:
                if (sc_tick)
                    st_d = GDFC_LOCK; // [R12]
            GDFC_LOCK:
                if (cmd_rise && !uv_lock)
                    st_d = GDFC_ON_RES; // [R13]
            default:
                st_d = GDFC_OFF;
        endcase
    end

    // Acknowledge: delay counter then width counter, restarted by each command edge.
    gdfc_cnt_t ack_dly_q;
    gdfc_cnt_t ack_w_q;
    logic      ack_wait_q;
    logic      ack_on_q;
    gdfc_cnt_t stretch_q;
    logic      gate_q;
    logic      status_q;

    wire logic sc_fault   = (st_q == GDFC_SC_DLY) || (st_q == GDFC_SC_BLK); // [R10] [R12]
    wire logic fault_now  = uv_lock || sc_fault; // [R6]
    wire logic fault_show = fault_now || (stretch_q != 16'h0000); // [R17]
    wire logic gate_d     = !uv_lock && (st_d == GDFC_ON_RES || st_d == GDFC_ON_OK
                                         || st_d == GDFC_SC_DLY); // [R1] [R5] [R11] [R13]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q           <= GDFC_OFF;
            sc_cnt_q       <= 16'h0000;
            cmd_dly_prev_q <= 1'b0;
            cmd_prev_q     <= 1'b0;
            ack_dly_q      <= 16'h0000;
            ack_w_q        <= 16'h0000;
            ack_wait_q     <= 1'b0;
            ack_on_q       <= 1'b0;
            stretch_q      <= 16'h0000;
            gate_q         <= 1'b0;
            status_q       <= 1'b0;
        end
        else
        begin
            st_q           <= st_d;
            sc_cnt_q       <= (st_d != st_q) ? 16'h0000 : sc_cnt_q + 16'h0001; // [R19]
            cmd_dly_prev_q <= cmd_dly;
            cmd_prev_q     <= cmd_q;
            // An edge during a running pulse lengthens it rather than cutting it short,
            // so the controller never sees a light-off pulse narrower than the minimum.
            if (cmd_edge && ack_on_q)
                ack_w_q <= 16'h0000; // [R4] [R16]
            else if (cmd_edge)
            begin
                ack_wait_q <= 1'b1;
                ack_dly_q  <= 16'h0000;
            end
            else if (ack_wait_q)
            begin
                ack_dly_q <= ack_dly_q + 16'h0001;
                if (done(ack_dly_q, ACK_DELAY_CYC))
                begin
                    ack_wait_q <= 1'b0;
                    ack_on_q   <= 1'b1;
                    ack_w_q    <= 16'h0000;
                end
            end
            else if (ack_on_q)
            begin
                ack_w_q <= ack_w_q + 16'h0001;
                if (done(ack_w_q, ACK_CYC))
                    ack_on_q <= 1'b0; // [R4] [R15] [R16]
            end
            // Stretch restarts while the undervoltage lock is present and counts down after.
            if (uv_lock)
                stretch_q <= STRETCH_CYC; // [R17]
            else if (stretch_q != 16'h0000)
                stretch_q <= stretch_q - 16'h0001;
            gate_q   <= gate_d;
            status_q <= !(fault_show || ack_on_q); // [R3] [R20]
        end
    end

    assign gate_on                  = gate_q;
    // The negative rail takes over the gate while locked, so the switch cannot creep on.
    assign positive_gate_rail_ctrl  = !uv_lock; // [R8]
    assign negative_gate_rail_ctrl  = uv_lock; // [R8]
    assign supply_undervoltage_lock = uv_lock;
    assign status_light_output      = status_q;
endmodule : gdfc_core

// [testbench/gdfc_core_asserts.sv]
// Port-level assertions of the gate driver fault controller.
`timescale 1ns/100ps
`include "gdfc_params.svh"
module gdfc_core_chk
    import gdfc_pkg::*;
#(
    parameter gdfc_cnt_t RESPONSE_CYC = 16'h0320,
    parameter gdfc_cnt_t BLOCK_CYC    = 16'h0320,
    parameter gdfc_cnt_t STRETCH_CYC  = 16'h0320
)
(
    // Clock, reset and inputs.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic command_light_input,
    input wire logic positive_rail_ok,
    input wire logic negative_rail_ok,
    input wire logic desat_over_threshold,
    // Outputs.
    input wire logic status_light_output,
    input wire logic gate_on,
    input wire logic positive_gate_rail_ctrl,
    input wire logic negative_gate_rail_ctrl,
    input wire logic supply_undervoltage_lock
);
    localparam int ACK_MIN = `GDFC_ACK_MIN_NS / `GDFC_CLK_PERIOD_NS;
    localparam int SC_LATE = 6;
    logic [15:0] low_q;
    logic [15:0] sc_q;
    logic        gate_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // The short-circuit count only runs for on-periods that began with desat already high.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            low_q  <= 16'h0000;
            sc_q   <= 16'h0000;
            gate_q <= 1'b0;
        end
        else
        begin
            gate_q <= gate_on;
            low_q  <= status_light_output ? 16'h0000 : low_q + {15'h0000, low_q != 16'hFFFF};
            if (!gate_on || !desat_over_threshold)
                sc_q <= 16'h0000;
            else if ((!gate_q || sc_q != 16'h0000) && sc_q != 16'hFFFF)
                sc_q <= sc_q + 16'h0001;
        end
    end
    AST_ACK_MIN: assert property ($rose(status_light_output) |->
        low_q >= ACK_MIN || low_q >= STRETCH_CYC) else $error("status low pulse too short");
    AST_UV_STATUS: assert property (supply_undervoltage_lock [*2] |->
        !status_light_output) else $error("status light on under lock");
    AST_UV_GATE: assert property (supply_undervoltage_lock [*4] |-> !gate_on)
        else $error("gate on under lock");
    AST_RAIL_HAND: assert property (negative_gate_rail_ctrl == supply_undervoltage_lock
        && positive_gate_rail_ctrl == !supply_undervoltage_lock) else $error("rail hand-over");
    AST_UV_HOLD: assert property ($fell(supply_undervoltage_lock) |->
        (!status_light_output) [*8]) else $error("lock fault not stretched");
    AST_GATE_RISE: assert property ($rose(gate_on) |-> !supply_undervoltage_lock)
        else $error("gate rose under lock");
    AST_SC_FLAG: assert property (sc_q == RESPONSE_CYC + SC_LATE |->
        !status_light_output) else $error("short circuit not flagged");
    AST_SC_OFF: assert property (sc_q <= RESPONSE_CYC + `GDFC_SC_OFF_CYC + 2 * SC_LATE)
        else $error("gate not off after short circuit");
    AST_CMD_OFF: assert property ($fell(command_light_input) ##1 (!command_light_input) [*8]
        ##1 (!command_light_input) [*8] ##1 (!command_light_input) [*8] |-> !gate_on)
        else $error("gate on without command");
    AST_ACK_SEEN: assert property ($changed(command_light_input) |->
        ##[20:40] !status_light_output) else $error("no acknowledge after command edge");
    cover property ($fell(gate_on) && desat_over_threshold);
    cover property ($rose(status_light_output));
    cover property ($fell(supply_undervoltage_lock));
endmodule : gdfc_core_chk
bind gdfc_core gdfc_core_chk #(.RESPONSE_CYC(RESPONSE_CYC), .BLOCK_CYC(BLOCK_CYC),
    .STRETCH_CYC(STRETCH_CYC)) gdfc_core_chk_inst (.sys_clk, .rst, .command_light_input,
    .positive_rail_ok, .negative_rail_ok, .desat_over_threshold, .status_light_output, .gate_on,
    .positive_gate_rail_ctrl, .negative_gate_rail_ctrl, .supply_undervoltage_lock);

// [testbench/gdfc_ctrl_model.sv]
// External controller model: sends the command light and times status light-off pulses.
`timescale 1ns/100ps
module gdfc_ctrl_model
(
    input  wire logic        sys_clk,
    input  wire logic        clr,
    input  wire logic        cmd_level,
    output logic             command_light_input,
    input  wire logic        status_light_output,
    output logic [7:0]       pulse_cnt,
    output logic [15:0]      max_low
);
    logic [15:0] run_q;
    // The bench already changes the level at the falling edge; passing it straight on
    // avoids a race between two processes woken by that same edge.
    always_comb
        command_light_input = cmd_level;
    // Each light-off pulse is counted and the widest width kept, so every edge can be supervised.
    always @(posedge sys_clk)
    begin
        run_q <= status_light_output ? 16'h0000 : run_q + 16'h0001;
        if (clr)
        begin
            pulse_cnt <= 8'h00;
            max_low   <= 16'h0000;
        end
        else if (status_light_output && run_q != 16'h0000)
        begin
            pulse_cnt <= pulse_cnt + 8'h01;
            max_low   <= (run_q > max_low) ? run_q : max_low;
        end
    end
endmodule : gdfc_ctrl_model

// [testbench/tb.sv]
// Self-checking bench of the gate driver fault controller.
`timescale 1ns/100ps
`include "gdfc_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import gdfc_pkg::*;
    logic sys_clk, rst, cmd_level, clr, positive_rail_ok, negative_rail_ok, desat_over_threshold;
    logic command_light_input, status_light_output, gate_on, pos_ctrl, neg_ctrl, uv_lock;
    logic [7:0]  pulse_cnt;
    logic [15:0] max_low;
    int num_errors, comparisons, seed;
    gdfc_core #(.RESPONSE_CYC(16'h0064), .BLOCK_CYC(16'h0014), .STRETCH_CYC(16'h0014))
        gdfc_core_inst (.sys_clk(sys_clk), .rst(rst), .command_light_input(command_light_input),
        .status_light_output(status_light_output), .positive_rail_ok(positive_rail_ok),
        .negative_rail_ok(negative_rail_ok), .desat_over_threshold(desat_over_threshold),
        .gate_on(gate_on), .positive_gate_rail_ctrl(pos_ctrl), .negative_gate_rail_ctrl(neg_ctrl),
        .supply_undervoltage_lock(uv_lock));
    gdfc_ctrl_model gdfc_ctrl_model_inst (.sys_clk(sys_clk), .clr(clr), .cmd_level(cmd_level),
        .command_light_input(command_light_input), .status_light_output(status_light_output),
        .pulse_cnt(pulse_cnt), .max_low(max_low));
    function automatic logic ack_ok(input logic [15:0] w);
        return w >= `GDFC_ACK_MIN_NS / `GDFC_CLK_PERIOD_NS && w <= `GDFC_ACK_MAX_NS / 10;
    endfunction : ack_ok
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic clear();
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
    endtask : clear
    task automatic edge_chk(input logic lvl, input int hold);
        cmd_level = lvl;
        tick(5);
        `CHK(gate_on, !lvl)
        tick(25);
        `CHK(gate_on, lvl)
        tick(hold - 30);
        `CHK(status_light_output, hold > `GDFC_ACK_DELAY_CYC + `GDFC_ACK_CYC + 10)
    endtask : edge_chk
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200us;
        num_errors++;
        results();
    end
    initial
    begin
        seed = 32'hE9E17E67;
        {rst, clr, positive_rail_ok, negative_rail_ok} = 4'hF;
        {cmd_level, desat_over_threshold} = 2'h0;
        tick(2);
        rst = 1'b0;
        `CHK(status_light_output, 1'b0)
        tick(120);
        `CHK(status_light_output, 1'b1)
        $display("test power-up done");
        clear();
        for (int i = 0; i < 6; i++)
            edge_chk(!cmd_level, 100 + int'($unsigned($random(seed)) % 200));
        `CHK(pulse_cnt, 8'h06)
        `CHK(ack_ok(max_low), 1'b1)
        $display("test random edges done");
        clear();
        edge_chk(1'b1, 30);
        edge_chk(1'b0, 120);
        `CHK(pulse_cnt, 8'h01)
        `CHK(ack_ok(max_low), 1'b1)
        $display("test merged edges done");
        for (int r = 0; r < 2; r++)
        begin
            edge_chk(1'b1, 120);
            {positive_rail_ok, negative_rail_ok} = r ? 2'h2 : 2'h1;
            tick(10);
            `CHK({gate_on, neg_ctrl, pos_ctrl}, 3'h2)
            tick(40);
            `CHK(status_light_output, 1'b0)
            {positive_rail_ok, negative_rail_ok} = 2'h3;
            tick(10);
            `CHK(status_light_output, 1'b0)
            tick(40);
            `CHK({status_light_output, gate_on}, 2'h2)
            cmd_level = 1'b0;
            tick(120);
        end
        $display("test undervoltage done");
        desat_over_threshold = 1'b1;
        cmd_level = 1'b1;
        tick(100);
        `CHK(status_light_output, 1'b1)
        tick(25);
        `CHK({status_light_output, gate_on}, 2'h1)
        tick(25);
        `CHK({status_light_output, gate_on}, 2'h0)
        tick(100);
        `CHK({status_light_output, gate_on}, 2'h2)
        desat_over_threshold = 1'b0;
        cmd_level = 1'b0;
        tick(120);
        edge_chk(1'b1, 120);
        $display("test short circuit done");
        results();
    end
endmodule : tb
